// >>> hw/clock_routing_pkg.sv
`default_nettype none
package clock_routing_pkg;
  // Register offsets on the serial control port.
  localparam logic [6:0] OFS_FRAC_LOW = 7'h04;
  localparam logic [6:0] OFS_FRAC_MID = 7'h05;
  localparam logic [6:0] OFS_FRAC_HIGH_INT = 7'h06;
  localparam logic [6:0] OFS_DIV_PIN_CLOCKS = 7'h07;
  localparam logic [6:0] OFS_CONV_CLOCK_SEL = 7'h08;
  localparam logic [6:0] OFS_RX_MASTER_CFG = 7'h09;
  localparam logic [6:0] OFS_TX_MASTER_CFG = 7'h0A;
  localparam int REG_COUNT = 7;
  localparam int REG_WIDTH = 9;
  localparam int ADDR_WIDTH = 7;
  localparam int WORD_BITS = ADDR_WIDTH + REG_WIDTH;
  localparam logic [3:0] WORD_LAST = 4'hF;
  // Values after reset.
  localparam logic [8:0] RST_FRAC_LOW = 9'h121;
  localparam logic [8:0] RST_FRAC_MID = 9'h17E;
  localparam logic [8:0] RST_FRAC_HIGH_INT = 9'h07D;
  localparam logic [8:0] RST_DIV_PIN_CLOCKS = 9'h190;
  localparam logic [8:0] RST_CONV_CLOCK_SEL = 9'h010;
  localparam logic [8:0] RST_RX_MASTER_CFG = 9'h002;
  localparam logic [8:0] RST_TX_MASTER_CFG = 9'h002;
  // Field positions.
  localparam int FRAC_TOP_LSB = 0;
  localparam int INT_LSB = 4;
  localparam int PRE_BIT = 0;
  localparam int POST_BIT = 1;
  localparam int DIV_LSB = 3;
  localparam int MCLK_SRC_LSB = 5;
  localparam int CLOCK_OUTPUT_PIN_SRC_LSB = 7;
  localparam int DAC_SEL_LSB = 0;
  localparam int ADC_SEL_LSB = 2;
  localparam int TX_SEL_LSB = 4;
  localparam int MANUAL_BIT = 6;
  localparam int RATE_LSB = 0;
  localparam int BCLK_LSB = 3;
  localparam int MASTER_BIT = 5;
  localparam int MSRC_LSB = 6;
  // Clock source codes.
  localparam logic [1:0] SRC_PIN = 2'h0;
  localparam logic [1:0] SRC_PLL1 = 2'h1;
  localparam logic [1:0] SRC_PLL2 = 2'h2;
  localparam logic [1:0] SRC_ALT = 2'h3;
  localparam logic [1:0] BCLK_IS_SYSCLK = 2'h3;
  // Routing used while automatic configuration is on.
  localparam logic [1:0] AUTO_DAC_SRC = 2'h0;
  localparam logic [1:0] AUTO_ADC_SRC = 2'h0;
  localparam logic [1:0] AUTO_SPDIF_SRC = 2'h1;
  // Synchronised clock levels, by index.
  localparam int LVL_PLL1 = 0;
  localparam int LVL_PLL2 = 1;
  localparam int LVL_OSC = 2;
  localparam int LVL_MCLK = 3;
  localparam int LVL_ADCM = 4;
  localparam int LVL_COUNT = 5;
  localparam int CNT_WIDTH = 11;
endpackage : clock_routing_pkg
`default_nettype wire

// >>> hw/codec_clock_routing_config.sv
`default_nettype none
module codec_clock_routing_config
  import clock_routing_pkg::*;
(
  input wire logic clk_in, // Core clock, 250 MHz.
  input wire logic nrst_in, // Asynchronous reset, active low.
  input wire logic ctrl_clk_in, // Serial control port clock.
  input wire logic ctrl_sel_n_in, // Serial word select, active low.
  input wire logic ctrl_data_in, // Serial data, MSB first.
  input wire logic first_pll_clock_in, // First PLL clock.
  input wire logic second_pll_clock_in, // Second PLL clock.
  input wire logic oscillator_clock_in, // Oscillator clock.
  input wire logic adc_master_clock_pin_in, // ADC master clock pin.
  input wire logic spdif_rx_mode_in, // PLLs in receiver mode.
  input wire logic first_pll_output_halver_in, // Host first post-scale.
  input wire logic [1:0] first_pll_output_divider_in, // Host first div.
  input wire logic [1:0] auto_divider_in, // Receiver-chosen divider.
  output logic [21:0] second_pll_fraction_out, // Fraction part.
  output logic [3:0] second_pll_integer_out, // Integer part.
  output logic second_pll_input_halver_out, // Input halver.
  output logic second_pll_output_halver_out, // Effective post-scale.
  output logic [1:0] second_pll_output_divider_out, // Effective div.
  output logic first_pll_output_halver_out, // Effective post-scale.
  output logic [1:0] first_pll_output_divider_out, // Effective div.
  output logic [1:0] dac_clock_source_out, // Effective DAC source.
  output logic [1:0] adc_clock_source_out, // Effective ADC source.
  output logic [1:0] spdif_transmit_clock_source_out, // Effective.
  input wire logic master_clock_pin_in, // Master clock pin level.
  output logic master_clock_pin_out, // Master clock pin drive.
  output logic master_clock_pin_oe_out, // Master clock pin enable.
  output logic clock_output_pin_out, // Clock output pin drive.
  output logic clock_output_pin_oe_out, // Clock output pin enable.
  input wire logic [1:0] bclk_pin_in, // BCLK pins, 0 rx, 1 tx.
  output logic [1:0] bclk_pin_out, // BCLK drive.
  output logic [1:0] bclk_pin_oe_out, // BCLK enable in master mode.
  input wire logic [1:0] lrclk_pin_in, // LRCLK pins, 0 rx, 1 tx.
  output logic [1:0] lrclk_pin_out, // LRCLK drive.
  output logic [1:0] lrclk_pin_oe_out // LRCLK enable in master mode.
);
  import clock_routing_pkg::*;

  // Serial control port, on its own clock.
  logic [3:0] bit_cnt_r;
  logic [WORD_BITS-2:0] shift_r;
  logic [WORD_BITS-1:0] word_r;
  logic word_tgl_r;

  // The select clears the count at once, as the clock stops between words.
  wire logic frame_rst_n = nrst_in & ~ctrl_sel_n_in;
  always_ff @(posedge ctrl_clk_in or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt_r <= 4'h0;
    end else begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge ctrl_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      shift_r <= '0;
      word_r <= '0;
      word_tgl_r <= 1'b0;
    end else if (!ctrl_sel_n_in) begin
      shift_r <= {shift_r[WORD_BITS-3:0], ctrl_data_in};
      if (bit_cnt_r == WORD_LAST) begin
        word_r <= {shift_r, ctrl_data_in};
        word_tgl_r <= ~word_tgl_r;
      end
    end
  end

  // The word stays put for a whole frame, so a toggle crossing is enough.
  logic tgl_s1_r, tgl_s2_r, tgl_s3_r, word_take;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_s3_r <= 1'b0;
    end else begin
      tgl_s1_r <= word_tgl_r;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
    end
  end

  assign word_take = tgl_s2_r ^ tgl_s3_r;

  logic [ADDR_WIDTH-1:0] wr_addr;
  logic [REG_WIDTH-1:0] wr_data;
  assign wr_addr = word_r[WORD_BITS-1:REG_WIDTH];
  assign wr_data = word_r[REG_WIDTH-1:0];

  // Register file; unmapped offsets are ignored.
  logic [REG_WIDTH-1:0] reg_r [REG_COUNT];
  localparam logic [REG_WIDTH-1:0] RST_TABLE [REG_COUNT] = '{
    RST_FRAC_LOW, RST_FRAC_MID, RST_FRAC_HIGH_INT, RST_DIV_PIN_CLOCKS,
    RST_CONV_CLOCK_SEL, RST_RX_MASTER_CFG, RST_TX_MASTER_CFG};

  genvar gr;
  generate
    for (gr = 0; gr < REG_COUNT; gr++) begin : g_reg
      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          reg_r[gr] <= RST_TABLE[gr];
        end else if (word_take &&
                     wr_addr == OFS_FRAC_LOW + ADDR_WIDTH'(gr)) begin
          reg_r[gr] <= wr_data;
        end
      end
    end
  endgenerate

  logic [8:0] frac_low, frac_mid, frac_hi, divpin, convsel;
  assign frac_low = reg_r[0];
  assign frac_mid = reg_r[1];
  assign frac_hi = reg_r[2];
  assign divpin = reg_r[3];
  assign convsel = reg_r[4];

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      second_pll_fraction_out <= '0;
      second_pll_integer_out <= 4'h0;
      second_pll_input_halver_out <= 1'b0;
      second_pll_output_halver_out <= 1'b0;
      second_pll_output_divider_out <= 2'h0;
      first_pll_output_halver_out <= 1'b0;
      first_pll_output_divider_out <= 2'h0;
    end else begin
      second_pll_fraction_out <=
        {frac_hi[FRAC_TOP_LSB +: 4], frac_mid, frac_low};
      second_pll_integer_out <= frac_hi[INT_LSB +: 4];
      second_pll_input_halver_out <= divpin[PRE_BIT];
      first_pll_output_halver_out <= first_pll_output_halver_in;
      if (spdif_rx_mode_in) begin
        second_pll_output_halver_out <= 1'b0;
        second_pll_output_divider_out <= 2'h0;
        first_pll_output_divider_out <= auto_divider_in;
      end else begin
        second_pll_output_halver_out <= divpin[POST_BIT];
        second_pll_output_divider_out <= divpin[DIV_LSB +: 2];
        first_pll_output_divider_out <= first_pll_output_divider_in;
      end
    end
  end

  // Converter routing.
  logic manual;
  assign manual = convsel[MANUAL_BIT];

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dac_clock_source_out <= AUTO_DAC_SRC;
      adc_clock_source_out <= AUTO_ADC_SRC;
      spdif_transmit_clock_source_out <= AUTO_SPDIF_SRC;
    end else if (manual) begin
      // Codes 00 and 11 both mean the master clock pin for the DAC.
      dac_clock_source_out <= (convsel[DAC_SEL_LSB +: 2] == SRC_ALT) ?
        SRC_PIN : convsel[DAC_SEL_LSB +: 2];
      adc_clock_source_out <= convsel[ADC_SEL_LSB +: 2];
      spdif_transmit_clock_source_out <= convsel[TX_SEL_LSB +: 2];
    end else begin
      dac_clock_source_out <= AUTO_DAC_SRC;
      adc_clock_source_out <= AUTO_ADC_SRC;
      spdif_transmit_clock_source_out <= AUTO_SPDIF_SRC;
    end
  end

  // Pin clock muxes pass the raw clocks straight through.
  logic [1:0] mclk_src, cko_src;
  assign mclk_src = divpin[MCLK_SRC_LSB +: 2];
  assign cko_src = divpin[CLOCK_OUTPUT_PIN_SRC_LSB +: 2];

  function automatic logic pick_clock(input logic [1:0] code,
                                      input logic pll1, input logic pll2,
                                      input logic osc);
    logic v;
    v = 1'b0;
    unique case (code)
      SRC_PLL1: v = pll1;
      SRC_PLL2: v = pll2;
      SRC_ALT: v = osc;
      SRC_PIN: v = 1'b0;
    endcase
    return v;
  endfunction : pick_clock

  assign master_clock_pin_oe_out = (mclk_src != SRC_PIN);
  assign master_clock_pin_out = pick_clock(mclk_src, first_pll_clock_in,
    second_pll_clock_in, oscillator_clock_in);
  assign clock_output_pin_oe_out = (cko_src != SRC_PIN);
  assign clock_output_pin_out = pick_clock(cko_src, first_pll_clock_in,
    second_pll_clock_in, oscillator_clock_in);

  // Sample every source clock through two flip-flops.
  logic mclk_level;
  logic [LVL_COUNT-1:0] lvl_raw;
  logic [LVL_COUNT-1:0] lvl_s1_r;
  logic [LVL_COUNT-1:0] lvl_r;
  assign mclk_level = master_clock_pin_oe_out ? master_clock_pin_out :
                      master_clock_pin_in;
  assign lvl_raw = {adc_master_clock_pin_in, mclk_level,
                    oscillator_clock_in, second_pll_clock_in,
                    first_pll_clock_in};

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lvl_s1_r <= '0;
      lvl_r <= '0;
    end else begin
      lvl_s1_r <= lvl_raw;
      lvl_r <= lvl_s1_r;
    end
  end

  // Master-mode clock generators, one per direction. Both directions use
  // the receiver's master source field.
  logic [1:0] msrc;
  logic [1:0] master;
  logic [CNT_WIDTH-1:0] frame_cnt_r [2];
  logic [CNT_WIDTH-1:0] ratio [2];
  assign msrc = reg_r[5][MSRC_LSB +: 2];

  genvar gd;
  generate
    for (gd = 0; gd < 2; gd++) begin : g_dir
      logic [8:0] cfg;
      logic src_lvl;
      logic src_prev_r;
      logic tick;
      logic [2:0] rate;
      logic [1:0] bsel;
      logic [CNT_WIDTH-1:0] per;
      logic [CNT_WIDTH-1:0] bcnt_r;
      logic bclk_r;
      logic lrclk_r;

      assign cfg = reg_r[5 + gd];
      assign master[gd] = cfg[MASTER_BIT];
      assign rate = cfg[RATE_LSB +: 3];
      assign bsel = cfg[BCLK_LSB +: 2];

      always_comb begin
        unique case (msrc)
          SRC_PLL1: src_lvl = lvl_r[LVL_PLL1];
          SRC_PLL2: src_lvl = lvl_r[LVL_PLL2];
          SRC_PIN, SRC_ALT: src_lvl = lvl_r[LVL_MCLK];
        endcase
        unique case (rate)
          3'h0: ratio[gd] = 11'd128;
          3'h1: ratio[gd] = 11'd192;
          3'h2: ratio[gd] = 11'd256;
          3'h3: ratio[gd] = 11'd384;
          3'h4: ratio[gd] = 11'd512;
          3'h5: ratio[gd] = 11'd768;
          3'h6: ratio[gd] = 11'd1152;
          default: ratio[gd] = 11'd256;
        endcase
        unique case (bsel)
          2'h0: per = ratio[gd] >> 6;
          2'h1: per = ratio[gd] >> 5;
          2'h2: per = ratio[gd] >> 4;
          BCLK_IS_SYSCLK: per = ratio[gd];
        endcase
      end

      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          src_prev_r <= 1'b0;
        end else begin
          src_prev_r <= src_lvl;
        end
      end

      assign tick = src_lvl & ~src_prev_r;

      // Frame and bit counters restart together, so BCLK falls on
      // every LRCLK edge unless bsel is BCLK_IS_SYSCLK.
      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          frame_cnt_r[gd] <= '0;
          bcnt_r <= '0;
        end else if (!master[gd]) begin
          frame_cnt_r[gd] <= '0;
          bcnt_r <= '0;
        end else if (tick) begin
          if (frame_cnt_r[gd] >= ratio[gd] - 11'd1) begin
            frame_cnt_r[gd] <= '0;
          end else begin
            frame_cnt_r[gd] <= frame_cnt_r[gd] + 11'd1;
          end
          if (frame_cnt_r[gd] >= ratio[gd] - 11'd1 ||
              bcnt_r >= per - 11'd1) begin
            bcnt_r <= '0;
          end else begin
            bcnt_r <= bcnt_r + 11'd1;
          end
        end
      end

      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          bclk_r <= 1'b0;
          lrclk_r <= 1'b0;
        end else if (!master[gd]) begin
          bclk_r <= 1'b0;
          lrclk_r <= 1'b0;
        end else begin
          bclk_r <= (bsel == BCLK_IS_SYSCLK) ? src_lvl :
                    (bcnt_r >= (per >> 1));
          lrclk_r <= (frame_cnt_r[gd] >= (ratio[gd] >> 1));
        end
      end

      // Slave directions leave both pins to the partner.
      assign bclk_pin_out[gd] = bclk_r;
      assign lrclk_pin_out[gd] = lrclk_r;
      assign bclk_pin_oe_out[gd] = master[gd];
      assign lrclk_pin_oe_out[gd] = master[gd];
    end
  endgenerate

  // Pin levels of slave directions are not used by this block.
  logic unused_pins;
  assign unused_pins = ^{bclk_pin_in, lrclk_pin_in};

  // Checks.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  sequence s_word_seen;
    word_take ##1 1'b1;
  endsequence

  a_fraction_write: assert property (
    s_word_seen |-> ##1 second_pll_fraction_out ==
      {frac_hi[3:0], frac_mid, frac_low})
    else $error("fraction output does not follow registers");
  a_integer_write: assert property (
    word_take && wr_addr == OFS_FRAC_HIGH_INT |->
      ##2 second_pll_integer_out == $past(wr_data[7:4], 2))
    else $error("integer part not taken from written word");
  a_input_halver: assert property (
    ##1 second_pll_input_halver_out == $past(divpin[PRE_BIT]))
    else $error("input halver does not track its bit");
  a_rx_mode_pll: assert property (
    $past(spdif_rx_mode_in) |-> !second_pll_output_halver_out &&
      first_pll_output_divider_out == $past(auto_divider_in))
    else $error("receiver mode PLL controls wrong");
  a_mclk_dir: assert property (
    master_clock_pin_oe_out == (divpin[6:5] != 2'h0))
    else $error("master clock pin direction wrong");
  a_clock_output_pin_dir: assert property (
    cko_src == 2'h0 |-> !clock_output_pin_oe_out)
    else $error("clock output pin not tristated");
  a_dac_route: assert property (
    manual && convsel[1:0] == 2'h3 |=> dac_clock_source_out == 2'h0)
    else $error("DAC code 11 must select master pin");
  a_auto_route: assert property (
    !manual |=> adc_clock_source_out == 2'h0 &&
      spdif_transmit_clock_source_out == 2'h1)
    else $error("automatic routing not applied");
  a_manual_route: assert property (
    manual |=> adc_clock_source_out == $past(convsel[3:2]))
    else $error("ADC select not followed");
  a_slave_release: assert property (
    !master[0] |-> !bclk_pin_oe_out[0] && !lrclk_pin_oe_out[0])
    else $error("slave receiver drives its clocks");
  a_lr_frame: assert property (
    master[0] && $changed(lrclk_pin_out[0]) && $past(master[0]) |->
      $past(frame_cnt_r[0]) == 11'd0 ||
      $past(frame_cnt_r[0]) == (ratio[0] >> 1))
    else $error("LRCLK edge off frame boundary");
  a_tx_master: assert property (
    master[1] |-> bclk_pin_oe_out[1] && lrclk_pin_oe_out[1])
    else $error("master transmitter not driving clocks");

endmodule : codec_clock_routing_config
`default_nettype wire

// >>> tb/audio_processor_model.sv
`default_nettype none
module audio_processor_model (
  input wire logic clk_in, // Processor clock.
  input wire logic nrst_in, // Reset, active low.
  input wire logic [1:0] bclk_oe_in, // Codec drives BCLK, 0 rx, 1 tx.
  input wire logic [1:0] bclk_drv_in, // Codec BCLK level.
  input wire logic [1:0] lrclk_oe_in, // Codec drives LRCLK.
  input wire logic [1:0] lrclk_drv_in, // Codec LRCLK level.
  output logic [1:0] bclk_pin_out, // Resolved BCLK wires.
  output logic [1:0] lrclk_pin_out // Resolved LRCLK wires.
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [8:0] phase_r;
  // Slave directions get clocks without pause, 64 bit clocks a frame.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      phase_r <= 9'h000;
    end else begin
      phase_r <= phase_r + 9'h001;
    end
  end
  // The processor lets go of a wire while the codec is master on it.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      bclk_pin_out[i] = bclk_oe_in[i] ? bclk_drv_in[i] : phase_r[2];
      lrclk_pin_out[i] = lrclk_oe_in[i] ? lrclk_drv_in[i] : phase_r[8];
    end
  end
endmodule : audio_processor_model
`default_nettype wire

// >>> tb/tb_codec_clock_routing_config.sv
`default_nettype none
module tb_codec_clock_routing_config;
  timeunit 1ns;
  timeprecision 100ps;
  import clock_routing_pkg::*;
  logic clk_in, nrst_in, ctrl_clk_in, ctrl_sel_n_in, ctrl_data_in;
  logic first_pll_clock_in, second_pll_clock_in, oscillator_clock_in;
  logic adc_master_clock_pin_in, ext_mclk, spdif_rx_mode_in;
  logic first_pll_output_halver_in, master_clock_pin_in;
  logic [1:0] first_pll_output_divider_in, auto_divider_in;
  logic [21:0] second_pll_fraction_out;
  logic [3:0] second_pll_integer_out;
  logic second_pll_input_halver_out, second_pll_output_halver_out;
  logic first_pll_output_halver_out, master_clock_pin_out;
  logic master_clock_pin_oe_out, clock_output_pin_out;
  logic clock_output_pin_oe_out;
  logic [1:0] second_pll_output_divider_out, first_pll_output_divider_out;
  logic [1:0] dac_clock_source_out, adc_clock_source_out;
  logic [1:0] spdif_transmit_clock_source_out;
  logic [1:0] bclk_pin_in, bclk_pin_out, bclk_pin_oe_out;
  logic [1:0] lrclk_pin_in, lrclk_pin_out, lrclk_pin_oe_out;
  int n_mismatch, comparisons;
  int tick = 0;

  always @(negedge clk_in) begin
    tick <= tick + 1;
  end
  // Source clocks of distinct periods, all slow enough to be sampled.
  assign first_pll_clock_in = (tick / 3) % 2 == 1;
  assign second_pll_clock_in = (tick / 5) % 2 == 1;
  assign oscillator_clock_in = (tick / 7) % 2 == 1;
  assign adc_master_clock_pin_in = (tick / 2) % 2 == 1;
  assign ext_mclk = (tick / 4) % 2 == 1;
  assign master_clock_pin_in = master_clock_pin_oe_out ?
    master_clock_pin_out : ext_mclk;

  codec_clock_routing_config codec_clock_routing_config_inst (
    .clk_in, .nrst_in, .ctrl_clk_in, .ctrl_sel_n_in, .ctrl_data_in,
    .first_pll_clock_in, .second_pll_clock_in, .oscillator_clock_in,
    .adc_master_clock_pin_in, .spdif_rx_mode_in,
    .first_pll_output_halver_in, .first_pll_output_divider_in,
    .auto_divider_in, .second_pll_fraction_out, .second_pll_integer_out,
    .second_pll_input_halver_out, .second_pll_output_halver_out,
    .second_pll_output_divider_out, .first_pll_output_halver_out,
    .first_pll_output_divider_out, .dac_clock_source_out,
    .adc_clock_source_out, .spdif_transmit_clock_source_out,
    .master_clock_pin_in, .master_clock_pin_out, .master_clock_pin_oe_out,
    .clock_output_pin_out, .clock_output_pin_oe_out,
    .bclk_pin_in, .bclk_pin_out, .bclk_pin_oe_out,
    .lrclk_pin_in, .lrclk_pin_out, .lrclk_pin_oe_out
  );

  audio_processor_model audio_processor_model_inst (
    .clk_in, .nrst_in, .bclk_oe_in(bclk_pin_oe_out),
    .bclk_drv_in(bclk_pin_out), .lrclk_oe_in(lrclk_pin_oe_out),
    .lrclk_drv_in(lrclk_pin_out), .bclk_pin_out(bclk_pin_in),
    .lrclk_pin_out(lrclk_pin_in)
  );

  task automatic check(input string what, input logic [21:0] exp,
      input logic [21:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  // Sends the first nbits of an address and data word, MSB first.
  task automatic write_word(input logic [6:0] addr, input logic [8:0] data,
      input int nbits);
    logic [15:0] word;
    word = {addr, data};
    @(negedge clk_in);
    #3 ctrl_sel_n_in = 1'b0;
    for (int i = 15; i > 15 - nbits; i--) begin
      ctrl_data_in = word[i];
      #40 ctrl_clk_in = 1'b1;
      #40 ctrl_clk_in = 1'b0;
    end
    #40 ctrl_sel_n_in = 1'b1;
    repeat (8) @(negedge clk_in);
  endtask : write_word

  task automatic check_reset;
    logic [21:0] e;
    e = {RST_FRAC_HIGH_INT[3:0], RST_FRAC_MID, RST_FRAC_LOW};
    check("fraction", e, second_pll_fraction_out);
    check("integer", 22'(4'h7), 22'(second_pll_integer_out));
    check("in halver", 22'(0), 22'(second_pll_input_halver_out));
    check("divider 2", 22'(2'b10), 22'(second_pll_output_divider_out));
    check("mclk enable", 22'(0), 22'(master_clock_pin_oe_out));
    check("clock_output_pin enable", 22'(1), 22'(clock_output_pin_oe_out));
    check("clock_output_pin", 22'(oscillator_clock_in), 22'(clock_output_pin_out));
    check("routing", 22'(6'h01), 22'({dac_clock_source_out,
      adc_clock_source_out, spdif_transmit_clock_source_out}));
    check("enables", 22'(0), 22'({bclk_pin_oe_out,
      lrclk_pin_oe_out}));
  endtask : check_reset

  task automatic check_ratio_fields;
    write_word(OFS_FRAC_LOW, 9'h0A5, 16);
    write_word(OFS_FRAC_MID, 9'h13C, 16);
    write_word(OFS_FRAC_HIGH_INT, 9'h0D9, 16);
    check("fraction", {4'h9, 9'h13C, 9'h0A5}, second_pll_fraction_out);
    check("integer", 22'(4'hD), 22'(second_pll_integer_out));
  endtask : check_ratio_fields

  task automatic check_refused;
    write_word(7'h0B, 9'h1FF, 16);
    write_word(7'h03, 9'h1FF, 16);
    write_word(OFS_FRAC_LOW, 9'h000, 8);
    check("fraction", {4'h9, 9'h13C, 9'h0A5}, second_pll_fraction_out);
    check("enables", 22'(0), 22'({bclk_pin_oe_out,
      lrclk_pin_oe_out}));
  endtask : check_refused

  task automatic check_receiver_mode;
    write_word(OFS_DIV_PIN_CLOCKS, 9'h18B, 16);
    check("in halver", 22'(1), 22'(second_pll_input_halver_out));
    check("out halver 2", 22'(1), 22'(second_pll_output_halver_out));
    check("divider 2", 22'(2'b01), 22'(second_pll_output_divider_out));
    check("divider 1", 22'(2'b10), 22'(first_pll_output_divider_out));
    write_word(OFS_FRAC_HIGH_INT, 9'h0D9, 16);
    // The first output halver stays under host control in receiver mode.
    spdif_rx_mode_in = 1'b1;
    repeat (4) @(negedge clk_in);
    check("out halver 2", 22'(0), 22'(second_pll_output_halver_out));
    check("out halver 1", 22'(1), 22'(first_pll_output_halver_out));
    check("divider 2", 22'(0), 22'(second_pll_output_divider_out));
    check("divider 1", 22'(2'b01), 22'(first_pll_output_divider_out));
    spdif_rx_mode_in = 1'b0;
    first_pll_output_halver_in = 1'b0;
    repeat (4) @(negedge clk_in);
    check("out halver 1", 22'(0), 22'(first_pll_output_halver_out));
  endtask : check_receiver_mode

  task automatic check_pin_sources;
    logic [3:0] src;
    for (int c = 0; c < 4; c++) begin
      write_word(OFS_DIV_PIN_CLOCKS, {c[1:0], c[1:0], 5'h00}, 16);
      for (int k = 0; k < 8; k++) begin
        @(posedge clk_in);
        src = {oscillator_clock_in, second_pll_clock_in, first_pll_clock_in,
          1'b0};
        check("mclk enable", 22'(c != 0), 22'(master_clock_pin_oe_out));
        check("clock_output_pin enable", 22'(c != 0),
          22'(clock_output_pin_oe_out));
        if (c != 0) begin
          check("mclk", 22'(src[c]), 22'(master_clock_pin_out));
          check("clock_output_pin", 22'(src[c]), 22'(clock_output_pin_out));
        end
      end
    end
  endtask : check_pin_sources

  task automatic check_routing;
    logic [1:0] t;
    for (int c = 0; c < 4; c++) begin
      t = 2'(c + 1);
      write_word(OFS_CONV_CLOCK_SEL, {3'b001, t, c[1:0], c[1:0]}, 16);
      check("dac", 22'((c == 3) ? 0 : c), 22'(dac_clock_source_out));
      check("adc", 22'(c), 22'(adc_clock_source_out));
      check("spdif", 22'(t), 22'(spdif_transmit_clock_source_out));
      write_word(OFS_CONV_CLOCK_SEL, {3'b000, t, c[1:0], c[1:0]}, 16);
      check("auto", 22'({AUTO_DAC_SRC, AUTO_ADC_SRC, AUTO_SPDIF_SRC}),
        22'({dac_clock_source_out, adc_clock_source_out,
        spdif_transmit_clock_source_out}));
    end
  endtask : check_routing

  // Counts source and bit clock rises over one frame of a master direction.
  task automatic measure(input int d, input logic [1:0] s,
      input logic [2:0] rate, input logic [1:0] bsel, input int ratio,
      input int nbits);
    logic [6:0] ofs;
    logic src, ps, pl, pb;
    int rises, guard, src_n, bclk_n;
    ofs = (d == 0) ? OFS_RX_MASTER_CFG : OFS_TX_MASTER_CFG;
    write_word(ofs, {1'b0, s, 1'b1, bsel, rate}, 16);
    check("enables", 22'({2'b11, 2'b00}), 22'({bclk_pin_oe_out[d],
      lrclk_pin_oe_out[d], bclk_pin_oe_out[1 - d],
      lrclk_pin_oe_out[1 - d]}));
    rises = 0;
    guard = 0;
    src_n = 0;
    bclk_n = 0;
    ps = 1'b1;
    pb = 1'b1;
    pl = 1'b1;
    while (rises < 2 && guard < 30000) begin
      @(negedge clk_in);
      guard++;
      src = (s == 2'b01) ? first_pll_clock_in :
        (s == 2'b10) ? second_pll_clock_in : master_clock_pin_in;
      if (lrclk_pin_out[d] && !pl) rises++;
      if (rises == 1 && src && !ps) src_n++;
      if (rises == 1 && bclk_pin_out[d] && !pb) bclk_n++;
      pl = lrclk_pin_out[d];
      ps = src;
      pb = bclk_pin_out[d];
    end
    check("source edges", 22'(ratio), 22'(src_n));
    check("bit clocks", 22'(nbits), 22'(bclk_n));
    write_word(ofs, {1'b0, s, 1'b0, bsel, rate}, 16);
    check("slave", 22'(0), 22'({bclk_pin_oe_out[d],
      lrclk_pin_oe_out[d]}));
  endtask : measure

  task automatic end_of_test;
    $display("mismatches %0d, comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  initial begin
    #350000;
    n_mismatch++;
    end_of_test;
  end

  initial begin
    n_mismatch = 0;
    comparisons = 0;
    nrst_in = 1'b0;
    ctrl_clk_in = 1'b0;
    ctrl_sel_n_in = 1'b1;
    ctrl_data_in = 1'b0;
    spdif_rx_mode_in = 1'b0;
    first_pll_output_halver_in = 1'b1;
    first_pll_output_divider_in = 2'b10;
    auto_divider_in = 2'b01;
    repeat (10) @(negedge clk_in);
    nrst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    check_reset;
    check_ratio_fields;
    check_refused;
    check_receiver_mode;
    check_pin_sources;
    check_routing;
    write_word(OFS_DIV_PIN_CLOCKS, 9'h180, 16);
    measure(0, 2'b10, 3'd0, 2'd2, 128, 16);
    measure(0, 2'b01, 3'd6, 2'd0, 1152, 64);
    measure(0, 2'b11, 3'd2, 2'd3, 256, 256);
    measure(1, 2'b00, 3'd1, 2'd1, 192, 32);
    measure(1, 2'b00, 3'd3, 2'd1, 384, 32);
    measure(1, 2'b00, 3'd4, 2'd0, 512, 64);
    measure(1, 2'b00, 3'd5, 2'd2, 768, 16);
    measure(1, 2'b00, 3'd7, 2'd0, 256, 64);
    end_of_test;
  end
endmodule : tb_codec_clock_routing_config
`default_nettype wire
